// ### rtl/mss_top.sv
/*
  module status and sleep control: sleep permission from the host modem
  line and the software setting, ring indicator for calls and messages,
  network status led patterns, and a serial receiver for host text.
  assumes all inputs are synchronous to clock; the command parser outside
  turns the sleep permit command text into a one-cycle strobe with its
  argument.
*/

// Operation
// - a low level on the host modem line forbids sleep.
// - a high level on the host modem line permits sleep.
// - the sleep permit command with argument 0 forbids and with argument 1 permits sleep.
// - after reset the software sleep setting forbids sleep.
// - ring indicator rests high, goes low for an incoming call and returns high when it is answered or dropped.
// - a received short message drives ring indicator low for at least 200 ms, then high.
// - the status led stays off while the module is not running.
// - without a network the led repeats 64 ms on and 800 ms off.
// - with a network and no packet session the led repeats 64 ms on and 3000 ms off.
// - the host controls the device with text commands over the asynchronous serial link.
// - the serial link runs at 115200 bit/s by default, other rates allowed.
// - characters are 8 data bits, no parity, 1 stop bit, no flow control.
module mss_top
  import mss_pkg::*;
#(
  parameter int unsigned MS_DIV = MS_CYCLES,
  parameter int unsigned BAUD = BAUD_DEFAULT
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // host modem line and command
  input wire logic dsr_line,
  input wire mss_sleep_cmd_t sleep_permit_command,
  // call and message events
  input wire logic call_ringing,
  input wire logic sms_received,
  // network state
  input wire mss_net_status_t net_status,
  // serial receive
  input wire logic rx_line,
  output mss_rx_byte_t rx_byte,
  // status outputs
  output logic sleep_active,
  output logic sw_sleep_permit,
  output logic ring_ind,
  output logic net_led
);

  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
  localparam int unsigned HALF_CYC = BIT_CYC / 2;
  localparam int unsigned BW = $clog2(BIT_CYC + 1);
  // one extra tick covers the unknown phase of the first tick
  localparam logic [MS_CNT_W-1:0] RI_HOLD = MS_CNT_W'(RI_SMS_MS);
  localparam logic [MS_CNT_W-1:0] ON_T = MS_CNT_W'(LED_ON_MS);

  generate
    if (BIT_CYC < 4) begin : g_bad_baud
      $error("mss_top: BAUD too high for the clock");
    end
  endgenerate

  // ------------------------------------------------------------------
  // millisecond timebase
  // ------------------------------------------------------------------
  logic ms_tick;

  mss_tick_div #(
    .DIV(MS_DIV)
  ) u_ms_div (
    .clock(clock),
    .reset_n(reset_n),
    .tick(ms_tick)
  );

  // ------------------------------------------------------------------
  // sleep permission
  // ------------------------------------------------------------------
  logic sw_permit_ff;
  logic nxt_sw_permit;
  logic sleep_ff;
  logic nxt_sleep;

  always_comb begin
    nxt_sw_permit = sw_permit_ff;
    if (sleep_permit_command.valid) begin
      nxt_sw_permit = sleep_permit_command.arg;
    end
    // low line forbids, high line permits; both must agree
    nxt_sleep = dsr_line & sw_permit_ff;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sw_permit_ff <= RST_SW_PERMIT;
      sleep_ff <= 1'b0;
    end else begin
      sw_permit_ff <= nxt_sw_permit;
      sleep_ff <= nxt_sleep;
    end
  end

  assign sleep_active = sleep_ff;
  assign sw_sleep_permit = sw_permit_ff;

  // ------------------------------------------------------------------
  // ring indicator
  // ------------------------------------------------------------------
  logic [MS_CNT_W-1:0] ri_cnt_ff;
  logic [MS_CNT_W-1:0] nxt_ri_cnt;
  logic ri_ff;
  logic nxt_ri;

  always_comb begin
    nxt_ri_cnt = ri_cnt_ff;
    if (sms_received) begin
      nxt_ri_cnt = RI_HOLD + 1'b1;
    end else if (ms_tick && ri_cnt_ff != '0) begin
      nxt_ri_cnt = ri_cnt_ff - 1'b1;
    end
    // low while a call rings or a message hold runs, high otherwise
    nxt_ri = !(call_ringing || sms_received || ri_cnt_ff != '0);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ri_cnt_ff <= '0;
      ri_ff <= RST_RI;
    end else begin
      ri_cnt_ff <= nxt_ri_cnt;
      ri_ff <= nxt_ri;
    end
  end

  assign ring_ind = ri_ff;

  // ------------------------------------------------------------------
  // network status led
  // ------------------------------------------------------------------
  mss_led_mode_t mode;
  logic [MS_CNT_W-1:0] off_t;
  logic [MS_CNT_W-1:0] led_cnt_ff;
  logic [MS_CNT_W-1:0] nxt_led_cnt;
  logic led_on_ff;
  logic nxt_led_on;
  mss_led_mode_t mode_ff;

  always_comb begin
    if (!net_status.running) begin
      mode = MSS_LED_OFF;
    end else if (!net_status.net_found) begin
      mode = MSS_LED_SEARCH;
    end else if (net_status.data_active) begin
      mode = MSS_LED_DATA;
    end else begin
      mode = MSS_LED_IDLE;
    end
    case (mode)
      MSS_LED_SEARCH: off_t = MS_CNT_W'(LED_OFF_SEARCH_MS);
      MSS_LED_IDLE: off_t = MS_CNT_W'(LED_OFF_IDLE_MS);
      MSS_LED_DATA: off_t = MS_CNT_W'(LED_OFF_DATA_MS);
      default: off_t = '0;
    endcase
    nxt_led_cnt = led_cnt_ff;
    nxt_led_on = led_on_ff;
    if (mode == MSS_LED_OFF) begin
      nxt_led_cnt = '0;
      nxt_led_on = 1'b0;
    end else if (mode != mode_ff) begin
      // pattern restarts with an on phase on every change into a running mode
      nxt_led_cnt = '0;
      nxt_led_on = 1'b1;
    end else if (ms_tick) begin
      nxt_led_cnt = led_cnt_ff + 1'b1;
      if (led_on_ff && led_cnt_ff == ON_T - 1'b1) begin
        nxt_led_cnt = '0;
        nxt_led_on = 1'b0;
      end else if (!led_on_ff && led_cnt_ff == off_t - 1'b1) begin
        nxt_led_cnt = '0;
        nxt_led_on = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      led_cnt_ff <= '0;
      led_on_ff <= RST_LED;
      mode_ff <= MSS_LED_OFF;
    end else begin
      led_cnt_ff <= nxt_led_cnt;
      led_on_ff <= nxt_led_on;
      mode_ff <= mode;
    end
  end

  assign net_led = led_on_ff;

  // ------------------------------------------------------------------
  // serial receiver, 8 data bits, no parity, 1 stop bit
  // ------------------------------------------------------------------
  mss_rx_state_t rx_st_ff;
  mss_rx_state_t nxt_rx_st;
  logic [BW-1:0] rx_cyc_ff;
  logic [BW-1:0] nxt_rx_cyc;
  logic [2:0] rx_bit_ff;
  logic [2:0] nxt_rx_bit;
  logic [DATA_BITS-1:0] rx_sh_ff;
  logic [DATA_BITS-1:0] nxt_rx_sh;
  mss_rx_byte_t rx_out_ff;
  mss_rx_byte_t nxt_rx_out;

  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_cyc = rx_cyc_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_out = rx_out_ff;
    nxt_rx_out.valid = 1'b0;
    nxt_rx_out.frame_err = 1'b0;
    if (rx_cyc_ff != '0) begin
      nxt_rx_cyc = rx_cyc_ff - 1'b1;
    end
    case (rx_st_ff)
      MSS_RX_IDLE: begin
        if (rx_line == 1'b0) begin
          nxt_rx_st = MSS_RX_START;
          nxt_rx_cyc = BW'(HALF_CYC - 1);
        end
      end
      MSS_RX_START: begin
        if (rx_cyc_ff == '0) begin
          if (rx_line == 1'b0) begin
            nxt_rx_st = MSS_RX_DATA;
            nxt_rx_cyc = BW'(BIT_CYC - 1);
            nxt_rx_bit = '0;
          end else begin
            nxt_rx_st = MSS_RX_IDLE;
          end
        end
      end
      MSS_RX_DATA: begin
        if (rx_cyc_ff == '0) begin
          nxt_rx_sh = {rx_line, rx_sh_ff[DATA_BITS-1:1]};
          nxt_rx_cyc = BW'(BIT_CYC - 1);
          nxt_rx_bit = rx_bit_ff + 1'b1;
          if (rx_bit_ff == 3'(DATA_BITS - 1)) begin
            nxt_rx_st = MSS_RX_STOP; // no parity bit
          end
        end
      end
      MSS_RX_STOP: begin
        if (rx_cyc_ff == '0) begin
          nxt_rx_st = MSS_RX_IDLE;
          // text is handled only while awake
          if (rx_line == 1'b1 && !sleep_ff) begin
            nxt_rx_out.data = rx_sh_ff;
            nxt_rx_out.valid = 1'b1;
          end else if (rx_line == 1'b0) begin
            nxt_rx_out.frame_err = 1'b1;
          end
        end
      end
      default: begin
        nxt_rx_st = MSS_RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_st_ff <= MSS_RX_IDLE;
      rx_cyc_ff <= '0;
      rx_bit_ff <= '0;
      rx_sh_ff <= '0;
      rx_out_ff <= '0;
    end else begin
      rx_st_ff <= nxt_rx_st;
      rx_cyc_ff <= nxt_rx_cyc;
      rx_bit_ff <= nxt_rx_bit;
      rx_sh_ff <= nxt_rx_sh;
      rx_out_ff <= nxt_rx_out;
    end
  end

  assign rx_byte = rx_out_ff;

endmodule // mss_top

// ### rtl/mss_pkg.sv
/*
  package for the module status and sleep control block: clock rate, time
  constants with derived cycle counts, serial frame layout, led patterns,
  reset values and the carrier types shared by the design files.
  assumes a single 200 MHz clock for every file that imports it.
*/
package mss_pkg;

  // ------------------------------------------------------------------
  // clock and timebase
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_HZ = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / TICK_HZ;

  // ------------------------------------------------------------------
  // serial link
  // ------------------------------------------------------------------
  localparam int unsigned BAUD_DEFAULT = 115200;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_DEFAULT;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned STOP_BITS = 1;

  // ------------------------------------------------------------------
  // pattern times in milliseconds
  // ------------------------------------------------------------------
  localparam int unsigned RI_SMS_MS = 200;
  localparam int unsigned LED_ON_MS = 64;
  localparam int unsigned LED_OFF_SEARCH_MS = 800;
  localparam int unsigned LED_OFF_IDLE_MS = 3000;
  localparam int unsigned LED_OFF_DATA_MS = 300;
  localparam int unsigned MS_CNT_W = 12;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic RST_SW_PERMIT = 1'h0;
  localparam logic RST_RI = 1'h1;
  localparam logic RST_LED = 1'h0;
  localparam logic RST_RX_IDLE = 1'h1;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    MSS_LED_OFF = 2'h0,
    MSS_LED_SEARCH = 2'h1,
    MSS_LED_IDLE = 2'h2,
    MSS_LED_DATA = 2'h3
  } mss_led_mode_t;

  typedef enum logic [1:0] {
    MSS_RX_IDLE = 2'h0,
    MSS_RX_START = 2'h1,
    MSS_RX_DATA = 2'h2,
    MSS_RX_STOP = 2'h3
  } mss_rx_state_t;

  typedef struct packed {
    logic running;
    logic net_found;
    logic data_active;
  } mss_net_status_t;

  typedef struct packed {
    logic valid;
    logic arg;
  } mss_sleep_cmd_t;

  typedef struct packed {
    logic [DATA_BITS-1:0] data;
    logic valid;
    logic frame_err;
  } mss_rx_byte_t;

endpackage : mss_pkg

// ### rtl/mss_tick_div.sv
/*
  divider that turns the 200 MHz clock into a one-cycle enable pulse once
  every DIV cycles; the status block uses it as its millisecond timebase.
  assumes reset_n is asynchronous and active low.
*/
module mss_tick_div
  import mss_pkg::*;
#(
  parameter int unsigned DIV = MS_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // enable pulse
  output logic tick
);

  localparam int unsigned CW = $clog2(DIV);

  generate
    if (DIV < 2) begin : g_bad_div
      $error("mss_tick_div: DIV must be at least 2");
    end
  endgenerate

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  always_comb begin
    nxt_tick = 1'b0;
    nxt_cnt = cnt_ff + 1'b1;
    if (cnt_ff == CW'(DIV - 1)) begin
      nxt_cnt = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule // mss_tick_div

// ### dv/mss_host_model.sv
/*
  host model: modem line, decoded sleep command and serial transmit.
  assumes the bench clock; drives on falling edges.
*/
module mss_host_model
  import mss_pkg::*;
#(
  parameter int unsigned BIT_CYC = 10
) (
  // clock
  input wire logic clock,
  // host lines
  output logic dsr_line,
  output mss_sleep_cmd_t sleep_permit_command,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    dsr_line = 1'h0;
    sleep_permit_command = '0;
    rx_line = 1'h1;
  end

  // modem line level, changed by this model only
  task automatic set_dsr(input logic v);
    dsr_line <= v;
  endtask

  task automatic permit(input logic arg);
    @(negedge clock);
    sleep_permit_command <= {1'h1, arg};
    @(negedge clock);
    sleep_permit_command <= '0;
  endtask

  // lsb first, no parity, one stop bit, no flow control
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clock);
      rx_line <= f[i];
      repeat (BIT_CYC - 1) @(negedge clock);
    end
    @(negedge clock);
    rx_line <= 1'h1;
  endtask
endmodule // mss_host_model

// ### dv/mss_top_checker.sv
/*
  assertions on the ports of the status and sleep block.
  assumes one clock and the active low asynchronous reset.
*/
module mss_top_checker
  import mss_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // inputs
  input wire logic dsr_line,
  input wire mss_sleep_cmd_t sleep_permit_command,
  input wire logic call_ringing,
  input wire logic sms_received,
  input wire mss_net_status_t net_status,
  input wire logic rx_line,
  // outputs
  input wire mss_rx_byte_t rx_byte,
  input wire logic sleep_active,
  input wire logic sw_sleep_permit,
  input wire logic ring_ind,
  input wire logic net_led
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_cmd(logic a);
    sleep_permit_command.valid && sleep_permit_command.arg == a;
  endsequence

  a_sleep_both_ok: assert property (sleep_active == $past(dsr_line && sw_sleep_permit))
    else $error("sleep differs from permissions");
  a_cmd_sets: assert property (s_cmd(1'h1) |=> sw_sleep_permit)
    else $error("permit command not applied");
  a_cmd_clears: assert property (s_cmd(1'h0) |=> !sw_sleep_permit)
    else $error("forbid command not applied");
  a_call_low: assert property (call_ringing |=> !ring_ind)
    else $error("ring high during call");
  a_sms_hold: assert property (sms_received |=> !ring_ind [*8])
    else $error("message ring too short");
  a_ring_release: assert property ($rose(ring_ind) |-> !$past(call_ringing))
    else $error("ring released while ringing");
  a_led_dark: assert property (!net_status.running [*2] |=> !net_led)
    else $error("led on while not running");
  a_led_on_min: assert property ($rose(net_led) |-> net_led [*8])
    else $error("led on phase too short");
endmodule // mss_top_checker

bind mss_top mss_top_checker i_chk (.clock(clock), .reset_n(reset_n), .dsr_line(dsr_line),
  .sleep_permit_command(sleep_permit_command), .call_ringing(call_ringing), .sms_received(sms_received),
  .net_status(net_status), .rx_line(rx_line), .rx_byte(rx_byte), .sleep_active(sleep_active),
  .sw_sleep_permit(sw_sleep_permit), .ring_ind(ring_ind), .net_led(net_led));

// ### dv/mss_top_bench.sv
/*
  bench for the status and sleep block with a host model at its far side.
  assumes a 200 MHz clock and shortened tick and bit times.
*/
module mss_top_bench
  import mss_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned MS = 4;
  localparam int unsigned BIT = 10;
  logic clock, reset_n, call_ringing, sms_received, rx_line, dsr_line;
  logic sleep_active, sw_sleep_permit, ring_ind, net_led;
  mss_sleep_cmd_t sleep_permit_command;
  mss_net_status_t net_status;
  mss_rx_byte_t rx_byte;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;

  mss_top #(.MS_DIV(MS), .BAUD(20_000_000)) i_mss_top (.clock(clock), .reset_n(reset_n), .dsr_line(dsr_line),
    .sleep_permit_command(sleep_permit_command), .call_ringing(call_ringing), .sms_received(sms_received),
    .net_status(net_status), .rx_line(rx_line), .rx_byte(rx_byte), .sleep_active(sleep_active),
    .sw_sleep_permit(sw_sleep_permit), .ring_ind(ring_ind), .net_led(net_led));
  mss_host_model #(.BIT_CYC(BIT)) host (.clock(clock), .dsr_line(dsr_line),
    .sleep_permit_command(sleep_permit_command), .rx_line(rx_line));

  // ----
  // helpers
  // ----
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'h1) begin
      err_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wait_led(input logic v, output int n);
    n = 0;
    while (net_led !== v && n < 20000) begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic rx_expect(input logic [7:0] b, input logic stop, input logic good);
    int n;
    logic v, e;
    n = 0;
    v = 1'h0;
    e = 1'h0;
    fork
      host.send(b, stop);
      while (n < 12 * BIT) begin
        @(negedge clock);
        v |= rx_byte.valid;
        e |= rx_byte.frame_err;
        n++;
      end
    join
    check(v === good && (!good || rx_byte.data === b), "byte");
    check(e === ~stop, "stop bit");
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset();
    check(sw_sleep_permit === 1'h0 && sleep_active === 1'h0, "sleep default");
    check(ring_ind === 1'h1 && net_led === 1'h0, "idle outputs");
  endtask

  task automatic t_sleep();
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      host.set_dsr(i[1]);
      host.permit(i[0]);
      @(negedge clock);
      check(sw_sleep_permit === i[0], "sw setting");
      check(sleep_active === (i[1] & i[0]), "sleep decision");
    end
  endtask

  task automatic t_serial();
    rx_expect(8'ha5, 1'h1, 1'h0);
    host.permit(1'h0);
    rx_expect(8'h3c, 1'h1, 1'h1);
    rx_expect(8'h81, 1'h0, 1'h0);
  endtask

  task automatic t_ring();
    int n;
    call_ringing <= 1'h1;
    repeat (2) @(negedge clock);
    check(ring_ind === 1'h0, "ring on call");
    call_ringing <= 1'h0;
    repeat (2) @(negedge clock);
    check(ring_ind === 1'h1, "ring after call");
    sms_received <= 1'h1;
    @(negedge clock);
    sms_received <= 1'h0;
    n = 0;
    while (ring_ind !== 1'h1 && n < 300 * MS) begin
      @(negedge clock);
      n++;
    end
    check(n >= 200 * MS && n <= 202 * MS, "message hold");
  endtask

  task automatic t_led();
    mss_net_status_t modes [3] = '{3'h4, 3'h6, 3'h7};
    int offs [3] = '{LED_OFF_SEARCH_MS, LED_OFF_IDLE_MS, LED_OFF_DATA_MS};
    int on_n, off_n, d;
    for (int m = 0; m < 3; m++) begin
      net_status <= modes[m];
      wait_led(1'h1, d);
      wait_led(1'h0, d);
      wait_led(1'h1, d);
      wait_led(1'h0, on_n);
      wait_led(1'h1, off_n);
      check(on_n >= (LED_ON_MS - 1) * MS && on_n <= (LED_ON_MS + 1) * MS, "led on");
      check(off_n >= (offs[m] - 1) * MS && off_n <= (offs[m] + 1) * MS, "led off");
    end
    wait_led(1'h0, d);
    net_status <= 3'h0;
    d = 0;
    repeat (400 * MS) begin
      @(negedge clock);
      d += int'(net_led !== 1'h0);
    end
    check(d == 0, "led dark");
  endtask

  // ----
  // clock, timeout, main
  // ----
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    reset_n = 1'h0;
    call_ringing = 1'h0;
    sms_received = 1'h0;
    net_status = 3'h0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    reset_n <= 1'h1;
    @(negedge clock);
    t_reset();
    t_sleep();
    t_serial();
    t_ring();
    t_led();
    summarize();
  end
endmodule // mss_top_bench
